// ==== core/acc_pkg.sv ====
package acc_pkg;
    localparam logic [1:0] ADDR_CTRL0     = 2'h0;
    localparam logic [1:0] ADDR_RES_HIGH  = 2'h1;
    localparam logic [1:0] ADDR_RES_LOW   = 2'h2;
    localparam logic [1:0] ADDR_IRQ_STAT  = 2'h3;
    localparam int         ADDR_W         = 4;
    localparam logic [3:0] ADDR_IRQ_EN    = 4'h4;
    localparam logic [3:0] ADDR_IRQ_CLR   = 4'h5;
    localparam int         BIT_ENABLE     = 0;
    localparam int         BIT_GO         = 1;
    localparam int         CHS_LSB        = 2;
    localparam int         CHS_W          = 5;
    localparam logic [7:0] CTRL0_RESET    = 8'h00;
    localparam logic [7:0] CTRL0_WMASK    = 8'h7F;
    localparam logic [4:0] CHS_LAST_EXT   = 5'h07;
    localparam logic [4:0] CHS_RSV_LO     = 5'h0C;
    localparam logic [4:0] CHS_RSV_HI     = 5'h1C;
    localparam logic [4:0] CHS_TEMP       = 5'h1D;
    localparam logic [4:0] CHS_DAC        = 5'h1E;
    localparam logic [4:0] CHS_FVR        = 5'h1F;
    localparam int         RES_W          = 10;
    localparam int         BIT_TIME       = 4;
    localparam int         SAMPLE_TIME    = 2;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } acc_bus_s;

    typedef enum logic [1:0] {
        SEL_NONE,
        SEL_EXT,
        SEL_TEMP,
        SEL_DAC
    } acc_src_e;
endpackage

// ==== core/acc_sar.sv ====
`timescale 1ns/10ps
module acc_sar #(
    parameter int RES_W = 10
) (
    input  wire logic             clk,
    input  wire logic             arst_n,
    input  wire logic             start,
    input  wire logic             abort,
    input  wire logic             bit_tick,
    input  wire logic             cmp_high,
    output logic                  busy,
    output logic                  done,
    output logic [RES_W-1:0]      result,
    output logic [RES_W-1:0]      trial_code
);
    logic [RES_W-1:0] trial;
    logic [RES_W-1:0] mask;
    logic [RES_W-1:0] next_trial;

    assign trial_code = trial;

    always_comb begin
        next_trial = cmp_high ? trial : (trial & ~mask);
    end

    logic last_bit;
    always_comb begin
        last_bit = 1'b0;
        for (int i = 0; i < RES_W - 1; i++) begin
            if (mask[i]) begin
                last_bit = trial[i+1];
            end
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            busy   <= 1'b0;
            done   <= 1'b0;
            trial  <= '0;
            mask   <= '0;
            result <= '0;
        end else begin
            done <= 1'b0;
            if (start && !busy) begin
                busy  <= 1'b1;
                mask  <= {1'b1, {(RES_W-1){1'b0}}};
                trial <= {1'b1, {(RES_W-1){1'b0}}};
            end else if (busy && abort) begin
                busy <= 1'b0;
                for (int i = 0; i < RES_W; i++) begin
                    if ((RES_W'(1) << i) <= mask) begin
                        result[i] <= last_bit;
                    end else begin
                        result[i] <= trial[i];
                    end
                end
            end else if (busy && bit_tick) begin
                if (mask[0]) begin
                    busy   <= 1'b0;
                    done   <= 1'b1;
                    result <= next_trial;
                end else begin
                    trial <= next_trial | (mask >> 1);
                    mask  <= mask >> 1;
                end
            end
        end
    end
endmodule

// ==== core/acc_ctrl.sv ====
`timescale 1ns/10ps
module acc_ctrl #(
    parameter int RES_W     = acc_pkg::RES_W,
    parameter int BIT_TIME  = acc_pkg::BIT_TIME
) (
    input  wire logic                  clk,
    input  wire logic                  arst_n,
    input  wire logic [3:0]            bus_addr,
    input  wire logic [7:0]            bus_wdata,
    input  wire logic                  bus_wr,
    input  wire logic                  bus_rd,
    output logic [7:0]                 bus_rdata,
    input  wire logic                  special_trigger,
    input  wire logic                  cmp_high,
    output logic                       timer_reset,
    output logic [7:0]                 analog_input_sel,
    output logic                       sel_temp,
    output logic                       sel_dac,
    output logic                       sel_fixed_reference_buffer,
    output logic                       converter_power,
    output logic                       sample_hold,
    output logic [RES_W-1:0]           dac_trial,
    output logic                       irq
);
    acc_pkg::acc_bus_s bus;
    assign bus = '{addr: bus_addr, wdata: bus_wdata, wr: bus_wr, rd: bus_rd};

    logic [4:0]        input_channel_select;
    logic              go;
    logic              converter_enable;
    logic              conversion_complete_flag;
    logic              irq_enable;
    logic [7:0]        result_high_byte;
    logic [7:0]        result_low_byte;
    logic              sync1;
    logic              sync2;
    logic              trig_prev;
    logic              trig_pulse;
    logic [7:0]        tick_cnt;
    logic              bit_tick;
    logic              eng_busy;
    logic              eng_done;
    logic [RES_W-1:0]  eng_result;
    logic [RES_W-1:0]  eng_trial;
    logic              abort_d;
    logic              wr_ctrl;
    logic              abort;
    logic              start;

    assign wr_ctrl = bus.wr && bus.addr == {2'h0, acc_pkg::ADDR_CTRL0};

    // trigger arrives from another block's pin side; synchronise before edge detect
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sync1     <= 1'b0;
            sync2     <= 1'b0;
            trig_prev <= 1'b0;
        end else begin
            sync1     <= special_trigger;
            sync2     <= sync1;
            trig_prev <= sync2;
        end
    end
    assign trig_pulse = sync2 && !trig_prev;

    // a write that clears go or turns the converter off while armed aborts
    // so a zero status bit never hides a running engine
    assign abort = wr_ctrl && go
                   && !(bus.wdata[acc_pkg::BIT_GO] && bus.wdata[acc_pkg::BIT_ENABLE]);
    // start needs the converter on; relies on software enabling first
    assign start = go && converter_enable && !eng_busy && !eng_done && !abort;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            input_channel_select <= '0;
            converter_enable     <= 1'b0;
        end else if (wr_ctrl) begin
            // bit 7 has no storage
            input_channel_select <= bus.wdata[acc_pkg::CHS_LSB +: acc_pkg::CHS_W];
            converter_enable     <= bus.wdata[acc_pkg::BIT_ENABLE];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            go <= 1'b0;
        end else if (eng_done) begin
            go <= 1'b0;
        end else if (trig_pulse) begin
            go <= 1'b1;
        end else if (wr_ctrl) begin
            // a write only arms go once the converter was already on and stays on; a trigger pulse arms go regardless
            go <= bus.wdata[acc_pkg::BIT_GO] && bus.wdata[acc_pkg::BIT_ENABLE]
                  && converter_enable;
        end else if (!converter_enable) begin
            go <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            timer_reset <= 1'b0;
        end else begin
            timer_reset <= trig_pulse;
        end
    end

    // bit clock divider, only runs during a conversion
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            tick_cnt <= '0;
            bit_tick <= 1'b0;
        end else if (!eng_busy) begin
            tick_cnt <= '0;
            bit_tick <= 1'b0;
        end else if (tick_cnt == 8'(BIT_TIME - 1)) begin
            tick_cnt <= '0;
            bit_tick <= 1'b1;
        end else begin
            tick_cnt <= tick_cnt + 8'h01;
            bit_tick <= 1'b0;
        end
    end

    acc_sar #(
        .RES_W      (RES_W)
    ) u_sar (
        .clk        (clk),
        .arst_n     (arst_n),
        .start      (start),
        .abort      (abort),
        .bit_tick   (bit_tick),
        .cmp_high   (cmp_high),
        .busy       (eng_busy),
        .done       (eng_done),
        .result     (eng_result),
        .trial_code (eng_trial)
    );

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            result_high_byte <= '0;
            result_low_byte  <= '0;
        end else if (eng_done || abort_d) begin
            // left justified; an abort is taken one cycle late, once the engine holds it
            result_high_byte <= 8'(eng_result >> (RES_W - 8));
            result_low_byte  <= 8'(eng_result << (16 - RES_W));
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            abort_d <= 1'b0;
        end else begin
            abort_d <= abort && eng_busy;
        end
    end

    // complete flag: set beats clear
    logic irq_clr;
    assign irq_clr = bus.wr && bus.addr == acc_pkg::ADDR_IRQ_CLR && bus.wdata[0];
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            conversion_complete_flag <= 1'b0;
        end else if (eng_done) begin
            conversion_complete_flag <= 1'b1;
        end else if (irq_clr) begin
            conversion_complete_flag <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq_enable <= 1'b0;
        end else if (bus.wr && bus.addr == acc_pkg::ADDR_IRQ_EN) begin
            irq_enable <= bus.wdata[0];
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            irq <= 1'b0;
        end else begin
            irq <= (conversion_complete_flag || eng_done) && irq_enable;
        end
    end

    // input mux decode
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            analog_input_sel           <= '0;
            sel_temp                   <= 1'b0;
            sel_dac                    <= 1'b0;
            sel_fixed_reference_buffer <= 1'b0;
        end else begin
            analog_input_sel <= '0;
            if (input_channel_select <= acc_pkg::CHS_LAST_EXT) begin
                analog_input_sel[input_channel_select[2:0]] <= 1'b1;
            end
            // codes 8..28 leave every source open
            sel_temp <= input_channel_select == acc_pkg::CHS_TEMP;
            sel_dac  <= input_channel_select == acc_pkg::CHS_DAC;
            sel_fixed_reference_buffer <= input_channel_select == acc_pkg::CHS_FVR;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            converter_power <= 1'b0;
            sample_hold     <= 1'b0;
            dac_trial       <= '0;
        end else begin
            converter_power <= converter_enable;
            sample_hold     <= eng_busy;
            dac_trial       <= eng_trial;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            bus_rdata <= '0;
        end else if (bus.rd) begin
            case (bus.addr)
                4'h0: bus_rdata <= {1'b0, input_channel_select, go, converter_enable};
                4'h1: bus_rdata <= result_high_byte;
                4'h2: bus_rdata <= result_low_byte;
                4'h3: bus_rdata <= {7'h00, conversion_complete_flag};
                4'h4: bus_rdata <= {7'h00, irq_enable};
                default: bus_rdata <= 8'h00;
            endcase
        end else begin
            bus_rdata <= 8'h00;
        end
    end

    a_go_clears: assert property (@(posedge clk) disable iff (!arst_n)
        eng_done |=> !go) else $error("status bit not cleared at completion");
    a_flag_sets: assert property (@(posedge clk) disable iff (!arst_n)
        eng_done |=> conversion_complete_flag) else $error("complete flag not set");
    a_bit7_zero: assert property (@(posedge clk) disable iff (!arst_n)
        $past(bus.rd) && $past(bus.addr) == 4'h0 |-> !bus_rdata[7])
        else $error("bit 7 read nonzero");
    a_temp_sel: assert property (@(posedge clk) disable iff (!arst_n)
        input_channel_select == acc_pkg::CHS_TEMP |=> sel_temp)
        else $error("temperature not selected");
    a_trig_go: assert property (@(posedge clk) disable iff (!arst_n)
        trig_pulse && !eng_done |=> go && timer_reset) else $error("trigger missed");
    a_power_off: assert property (@(posedge clk) disable iff (!arst_n)
        !converter_enable |=> !converter_power) else $error("power while disabled");
    a_rsv_none: assert property (@(posedge clk) disable iff (!arst_n)
        input_channel_select >= acc_pkg::CHS_RSV_LO && input_channel_select <= acc_pkg::CHS_RSV_HI
        |=> analog_input_sel == 8'h00 && !sel_temp && !sel_dac && !sel_fixed_reference_buffer)
        else $error("reserved routed");
    a_ext_sel: assert property (@(posedge clk) disable iff (!arst_n)
        input_channel_select == 5'h03 |=> analog_input_sel == 8'h08)
        else $error("external route wrong");
    a_go_refused: assert property (@(posedge clk) disable iff (!arst_n)
        wr_ctrl && !converter_enable && !trig_pulse |=> !go)
        else $error("status bit armed while converter off");
    a_go_arms: assert property (@(posedge clk) disable iff (!arst_n)
        wr_ctrl && bus.wdata[acc_pkg::BIT_GO] && bus.wdata[acc_pkg::BIT_ENABLE]
        && converter_enable && !eng_done |=> go) else $error("status write did not arm");
    a_go_holds: assert property (@(posedge clk) disable iff (!arst_n)
        go && !eng_done && !wr_ctrl && converter_enable |=> go)
        else $error("status bit dropped during conversion");
    a_busy_go: assert property (@(posedge clk) disable iff (!arst_n)
        eng_busy |-> go) else $error("engine runs while status reads idle");
    a_abort_stop: assert property (@(posedge clk) disable iff (!arst_n)
        abort && eng_busy && !trig_pulse |=> !eng_busy && !go)
        else $error("conversion not stopped by clear");
    a_timer_pulse: assert property (@(posedge clk) disable iff (!arst_n)
        timer_reset |=> !timer_reset) else $error("timer clear longer than one cycle");
    a_irq_level: assert property (@(posedge clk) disable iff (!arst_n)
        conversion_complete_flag && irq_enable |=> irq) else $error("interrupt not raised");
    a_fvr_sel: assert property (@(posedge clk) disable iff (!arst_n)
        input_channel_select == acc_pkg::CHS_FVR |=> sel_fixed_reference_buffer)
        else $error("reference buffer not selected");
    a_dac_sel: assert property (@(posedge clk) disable iff (!arst_n)
        input_channel_select == acc_pkg::CHS_DAC |=> sel_dac)
        else $error("dac output not selected");
    a_one_route: assert property (@(posedge clk) disable iff (!arst_n)
        $onehot0(analog_input_sel)) else $error("two external inputs routed");
    a_power_on: assert property (@(posedge clk) disable iff (!arst_n)
        converter_enable |=> converter_power) else $error("converter not powered");
    a_stat_read: assert property (@(posedge clk) disable iff (!arst_n)
        bus.rd && bus.addr == 4'h0 |=> bus_rdata[acc_pkg::BIT_GO] == $past(go))
        else $error("status bit read wrong");
    c_done: cover property (@(posedge clk) disable iff (!arst_n) eng_done);
    c_abort: cover property (@(posedge clk) disable iff (!arst_n) abort && eng_busy);
    c_trig: cover property (@(posedge clk) disable iff (!arst_n) trig_pulse);
    c_go_refused: cover property (@(posedge clk) disable iff (!arst_n)
        wr_ctrl && bus.wdata[acc_pkg::BIT_GO] && !converter_enable);
    c_irq: cover property (@(posedge clk) disable iff (!arst_n) irq);
endmodule

// ==== tb/adc_channel_and_conversion_control_tb.sv ====
`timescale 1ns/10ps
module adc_channel_and_conversion_control_tb;
    localparam logic [3:0] A_CTL  = 4'(acc_pkg::ADDR_CTRL0);
    localparam logic [3:0] A_HI   = 4'(acc_pkg::ADDR_RES_HIGH);
    localparam logic [3:0] A_LO   = 4'(acc_pkg::ADDR_RES_LOW);
    localparam logic [3:0] A_STAT = 4'(acc_pkg::ADDR_IRQ_STAT);
    localparam int         CONV   = acc_pkg::RES_W * acc_pkg::BIT_TIME;
    logic                           clk;
    logic                           arst_n;
    logic [3:0]                     bus_addr;
    logic [7:0]                     bus_wdata;
    logic                           bus_wr;
    logic                           bus_rd;
    logic [7:0]                     bus_rdata;
    logic                           special_trigger;
    logic                           cmp_high;
    logic                           timer_reset;
    logic [7:0]                     analog_input_sel;
    logic                           sel_temp;
    logic                           sel_dac;
    logic                           sel_fixed_reference_buffer;
    logic                           converter_power;
    logic                           sample_hold;
    logic [acc_pkg::RES_W-1:0]      dac_trial;
    logic                           irq;
    logic                           rd_pend;
    logic [7:0]                     exp_q[$];
    int                             miscompares;
    int                             checks_done;

    acc_ctrl u_dut (
        .clk                        (clk),
        .arst_n                     (arst_n),
        .bus_addr                   (bus_addr),
        .bus_wdata                  (bus_wdata),
        .bus_wr                     (bus_wr),
        .bus_rd                     (bus_rd),
        .bus_rdata                  (bus_rdata),
        .special_trigger            (special_trigger),
        .cmp_high                   (cmp_high),
        .timer_reset                (timer_reset),
        .analog_input_sel           (analog_input_sel),
        .sel_temp                   (sel_temp),
        .sel_dac                    (sel_dac),
        .sel_fixed_reference_buffer (sel_fixed_reference_buffer),
        .converter_power            (converter_power),
        .sample_hold                (sample_hold),
        .dac_trial                  (dac_trial),
        .irq                        (irq)
    );

    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    task automatic chk(input string nm, input logic [9:0] e, input logic [9:0] g);
        checks_done++;
        if (g !== e) begin
            miscompares++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // read data is registered, so it is compared half a cycle after it lands
    always @(negedge clk) begin
        if (rd_pend) chk("bus_rdata", {2'h0, exp_q.pop_front()}, {2'h0, bus_rdata});
        rd_pend = bus_rd;
    end

    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        bus_addr  <= a;
        bus_wdata <= d;
        bus_wr    <= 1'b1;
        @(posedge clk);
        bus_wr    <= 1'b0;
    endtask

    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        @(posedge clk);
        bus_addr <= a;
        bus_rd   <= 1'b1;
        @(posedge clk);
        bus_rd   <= 1'b0;
    endtask

    function automatic logic pick(input int k);
        return (k == 0) ? sample_hold : timer_reset;
    endfunction

    // bounded wait; a timeout shows up as a level mismatch
    task automatic wait_lvl(input int k, input logic lvl, input string nm, output int n);
        n = 0;
        @(negedge clk);
        while (pick(k) !== lvl && n < 300) begin
            @(negedge clk);
            n++;
        end
        chk(nm, {9'h0, lvl}, {9'h0, pick(k)});
    endtask

    task automatic results(input logic c);
        rd(A_HI, c ? 8'hFF : 8'h00);
        rd(A_LO, c ? 8'hC0 : 8'h00);
    endtask

    task automatic tally_and_finish;
        repeat (3) @(posedge clk);
        if (exp_q.size() != 0) begin
            miscompares++;
        end
        $display("checks %0d mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask

    initial begin
        #(20000 * 4);
        miscompares++;
        tally_and_finish();
    end

    initial begin
        logic [4:0] cd;
        logic       c;
        int         n;
        arst_n = 1'b0; bus_addr = 4'h0; bus_wdata = 8'h00; bus_wr = 1'b0; bus_rd = 1'b0;
        special_trigger = 1'b0; cmp_high = 1'b0; rd_pend = 1'b0;
        miscompares = 0; checks_done = 0;
        void'($urandom(32'hE3CA));
        repeat (8) @(posedge clk);
        arst_n <= 1'b1;
        rd(A_CTL, 8'h00);
        @(negedge clk);
        chk("converter_power", 10'h0, {9'h0, converter_power});
        // go with the converter off must not start anything
        wr(A_CTL, 8'h02);
        repeat (4) @(negedge clk);
        chk("sample_hold", 10'h0, {9'h0, sample_hold});
        rd(A_CTL, 8'h00);
        for (int k = 0; k < 32; k++) begin
            cd = 5'(k);
            wr(A_CTL, {1'b1, cd, 2'b01});
            rd(A_CTL, {1'b0, cd, 2'b01});
            @(negedge clk);
            chk("converter_power", 10'h1, {9'h0, converter_power});
            if (cd <= acc_pkg::CHS_LAST_EXT || cd >= acc_pkg::CHS_RSV_LO) begin
                chk("analog_input_sel", (cd <= acc_pkg::CHS_LAST_EXT) ? 10'h1 << cd : 10'h0,
                    {2'h0, analog_input_sel});
                chk("sel_temp", {9'h0, cd == acc_pkg::CHS_TEMP}, {9'h0, sel_temp});
                chk("sel_dac", {9'h0, cd == acc_pkg::CHS_DAC}, {9'h0, sel_dac});
                chk("sel_fixed_reference_buffer", {9'h0, cd == acc_pkg::CHS_FVR},
                    {9'h0, sel_fixed_reference_buffer});
            end
        end
        // full conversion started by software
        wr(A_CTL, 8'h01);
        c = 1'($urandom);
        cmp_high <= c;
        wr(A_CTL, 8'h03);
        rd(A_CTL, 8'h03);
        wait_lvl(0, 1'b0, "sample_hold", n);
        chk("conv_len_ok", 10'h1, {9'h0, n >= CONV && n <= CONV + 2});
        rd(A_CTL, 8'h01);
        rd(A_STAT, 8'h01);
        results(c);
        chk("irq", 10'h0, {9'h0, irq});
        wr(4'(acc_pkg::ADDR_IRQ_EN), 8'h01);
        repeat (2) @(negedge clk);
        chk("irq", 10'h1, {9'h0, irq});
        wr(4'(acc_pkg::ADDR_IRQ_CLR), 8'h01);
        repeat (2) @(negedge clk);
        chk("irq", 10'h0, {9'h0, irq});
        rd(A_STAT, 8'h00);
        rd(4'hF, 8'h00);
        // abort mid-way; the opposite comparator level proves the result was reloaded
        c = ~c;
        cmp_high <= c;
        wr(A_CTL, 8'h03);
        repeat (3 * acc_pkg::BIT_TIME) @(posedge clk);
        wr(A_CTL, 8'h01);
        wait_lvl(0, 1'b0, "sample_hold", n);
        repeat (3) @(posedge clk);
        rd(A_CTL, 8'h01);
        results(c);
        // hardware trigger
        c = ~c;
        cmp_high <= c;
        @(posedge clk);
        special_trigger <= 1'b1;
        wait_lvl(1, 1'b1, "timer_reset", n);
        wait_lvl(0, 1'b1, "sample_hold", n);
        chk("dac_trial", 10'h1 << (acc_pkg::RES_W - 1), dac_trial);
        @(posedge clk);
        special_trigger <= 1'b0;
        wait_lvl(0, 1'b0, "sample_hold", n);
        rd(A_CTL, 8'h01);
        results(c);
        // second reset in the middle of a conversion
        wr(A_CTL, 8'h03);
        repeat (5) @(posedge clk);
        arst_n <= 1'b0;
        repeat (2) @(posedge clk);
        arst_n <= 1'b1;
        @(negedge clk);
        chk("sample_hold", 10'h0, {9'h0, sample_hold});
        chk("converter_power", 10'h0, {9'h0, converter_power});
        chk("irq", 10'h0, {9'h0, irq});
        rd(A_CTL, 8'h00);
        // go in the same write that powers up is ignored
        wr(A_CTL, 8'h03);
        rd(A_CTL, 8'h01);
        repeat (2) @(negedge clk);
        chk("sample_hold", 10'h0, {9'h0, sample_hold});
        tally_and_finish();
    end
endmodule
